// ### rtl/fgc_frame_gen_chk.sv
// Frame generator configuration, payload source and checker counters with APB registers.
// Assumes events and frame-accept come from logic on the same clock.
// Notes on behaviour
// - Keep 32-bit errored-frame count; upper half is a read-only word.
// - Writing status bit 0 freezes the readable errored count; bit 1 zeroes it.
// - Count mode zero makes the errored counter saturate instead of wrap.
// - Fill byte in control bits 15:8, resets to 0x55, used in fixed mode.
// - Payload mode: 0 incrementing, 1 fixed fill, 2 and 3 pseudo-random.
// - Valid pattern bytes 0..6; code 7 means six.
// - Burst codes 0..6 send 1 to 1000000 frames; code 7 sends forever.
// - Control word resets to 0x5511.
// - 48-bit user pattern in three RW words, low first, reset zero.
// - 48-bit destination match value in three RW words, compared to DA.
// - Bit 1 of checksum flags shows CRC error of last received frame.
// - Bit 0 of checksum flags shows CRC error of last sent frame.
// - Low half of sent-frame counter is a read-only word, zero at reset.
// - Reading low, high, errored transmit words in order clears them.
// - Status bit 0 freezes the readable errored count; bit 1 zeroes both the count and its readable copy.
module fgc_frame_gen_chk #(
  parameter int unsigned FRAME_LEN = 64,
  parameter int unsigned GAP_LEN = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fgc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Checker and transmitter events
  input wire fgc_pkg::fgc_evt_s evt,
  input wire logic [47:0] rxDestAddr,
  input wire logic countWrap,
  // Payload stream
  input wire logic txReady,
  output fgc_pkg::fgc_byte_s txByte,
  output logic [47:0] userPattern,
  output logic [2:0] patternBytes,
  output logic [47:0] destMatch,
  output logic genBusy
);
  import fgc_pkg::*;

  logic [15:0] genCtrl;
  logic [15:0] patLo, patMid, patHi, daLo, daMid, daHi;
  logic [31:0] errCnt, errShadow;
  logic [31:0] txCnt;
  logic [15:0] txErrCnt;
  logic [1:0] crcFlags;
  logic [1:0] seqStep;
  logic errOverflow;
  fgc_state_e state;
  logic [19:0] framesLeft;
  logic [15:0] byteIdx;
  logic [7:0] incByte;
  logic [15:0] lfsr;
  logic [7:0] gapCnt;

  // Bus decode; word index sits at paddr[13:2]
  logic acc, wr, rd;
  logic [11:0] idx;
  logic known;
  assign idx = paddr[13:2];
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign pready = 1'b1;
  assign known = (paddr[1:0] == 2'b00) && (paddr[15:14] == 2'b00) &&
    (idx inside {IDX_GEN_CTRL, IDX_PAT_LO, IDX_PAT_MID, IDX_PAT_HI, IDX_DA_LO,
    IDX_DA_MID, IDX_DA_HI, IDX_CHK_STATUS, IDX_ERR_LO, IDX_ERR_HI,
    IDX_CRC_FLAGS, IDX_TX_LO, IDX_TX_HI, IDX_TX_ERR, IDX_GEN_START});
  assign pslverr = acc && !known;

  logic freezeWr, clearWr, startWr;
  assign freezeWr = wr && idx == IDX_CHK_STATUS &&
    (pwdata[FREEZE_BIT] || pwdata[CLEAR_BIT]);
  assign clearWr = wr && idx == IDX_CHK_STATUS && pwdata[CLEAR_BIT];
  assign startWr = wr && idx == IDX_GEN_START && pwdata[0];

  // Configuration registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      genCtrl <= GEN_CTRL_RST;
      patLo <= 16'h0000;
      patMid <= 16'h0000;
      patHi <= 16'h0000;
      daLo <= 16'h0000;
      daMid <= 16'h0000;
      daHi <= 16'h0000;
    end else if (wr) begin
      case (idx)
        IDX_GEN_CTRL: genCtrl <= pwdata[15:0];
        IDX_PAT_LO: patLo <= pwdata[15:0];
        IDX_PAT_MID: patMid <= pwdata[15:0];
        IDX_PAT_HI: patHi <= pwdata[15:0];
        IDX_DA_LO: daLo <= pwdata[15:0];
        IDX_DA_MID: daMid <= pwdata[15:0];
        IDX_DA_HI: daHi <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  assign userPattern = {patHi, patMid, patLo};
  assign destMatch = {daHi, daMid, daLo};
  // Code 7 is treated as six bytes
  assign patternBytes = (genCtrl[VLD_LSB+:3] > MAX_VLD) ? MAX_VLD : genCtrl[VLD_LSB+:3];

  // Errored-frame counter: counts checker-rejected frames for our DA
  logic errEvt;
  assign errEvt = evt.rxFrameEnd && evt.rxCrcBad && (rxDestAddr == destMatch);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      errCnt <= 32'h0;
      errOverflow <= 1'b0;
    end else if (clearWr) begin
      // A frame in the clearing cycle is kept, and its overflow wins over the clear
      errCnt <= {31'h0, errEvt};
      errOverflow <= errEvt && errCnt == CNT_MAX;
    end else if (errEvt) begin
      if (errCnt == CNT_MAX) begin
        errOverflow <= 1'b1;
        if (countWrap) begin
          errCnt <= 32'h0;
        end
      end else begin
        errCnt <= errCnt + 32'h1;
      end
    end
  end

  // Readable copy taken at freeze time
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      errShadow <= 32'h0;
    end else if (clearWr) begin
      errShadow <= 32'h0;
    end else if (freezeWr) begin
      errShadow <= errCnt;
    end
  end

  // Checksum flags follow the last frame of each path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      crcFlags <= 2'b00;
    end else begin
      if (evt.rxFrameEnd) begin
        crcFlags[RX_CRC_BIT] <= evt.rxCrcBad;
      end
      if (evt.txFrameEnd) begin
        crcFlags[TX_CRC_BIT] <= evt.txCrcBad;
      end
    end
  end

  // Read sequence tracker: low, high, errored words in order
  logic seqDone;
  assign seqDone = rd && idx == IDX_TX_ERR && seqStep == 2'd2;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seqStep <= 2'd0;
    end else if (rd) begin
      if (idx == IDX_TX_LO) begin
        seqStep <= 2'd1;
      end else if (idx == IDX_TX_HI && seqStep == 2'd1) begin
        seqStep <= 2'd2;
      end else begin
        seqStep <= 2'd0;
      end
    end
  end

  // Transmit statistics; an event in the clearing cycle is kept
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txCnt <= 32'h0;
      txErrCnt <= 16'h0;
    end else if (seqDone) begin
      txCnt <= {31'h0, evt.txFrameEnd};
      txErrCnt <= {15'h0, evt.txFrameEnd && evt.txCrcBad};
    end else if (evt.txFrameEnd) begin
      txCnt <= txCnt + 32'h1;
      if (evt.txCrcBad) begin
        txErrCnt <= txErrCnt + 16'h1;
      end
    end
  end

  // Burst length lookup
  function automatic logic [19:0] burstFrames(input logic [2:0] code);
    case (code)
      3'd0: burstFrames = 20'd1;
      3'd1: burstFrames = 20'd10;
      3'd2: burstFrames = 20'd100;
      3'd3: burstFrames = 20'd1000;
      3'd4: burstFrames = 20'd10000;
      3'd5: burstFrames = 20'd100000;
      default: burstFrames = 20'd1000000;
    endcase
  endfunction

  logic burstCont, byteGo, frameEnd;
  assign burstCont = genCtrl[BURST_LSB+:3] == BURST_CONT;
  assign byteGo = state == FGC_SEND && txReady;
  assign frameEnd = byteGo && byteIdx == 16'(FRAME_LEN - 1);

  // Generator sequencing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= FGC_IDLE;
      framesLeft <= 20'h0;
      byteIdx <= 16'h0;
      gapCnt <= 8'h0;
    end else begin
      case (state)
        FGC_IDLE: begin
          if (startWr) begin
            framesLeft <= burstFrames(genCtrl[BURST_LSB+:3]);
            byteIdx <= 16'h0;
            state <= FGC_SEND;
          end
        end
        FGC_SEND: begin
          if (frameEnd) begin
            byteIdx <= 16'h0;
            gapCnt <= 8'h0;
            if (!burstCont) begin
              framesLeft <= framesLeft - 20'h1;
            end
            state <= (!burstCont && framesLeft == 20'h1) ? FGC_IDLE : FGC_GAP;
          end else if (byteGo) begin
            byteIdx <= byteIdx + 16'h1;
          end
        end
        FGC_GAP: begin
          gapCnt <= gapCnt + 8'h1;
          if (gapCnt == 8'(GAP_LEN - 1)) begin
            state <= FGC_SEND;
          end
        end
        default: state <= FGC_IDLE;
      endcase
    end
  end
  assign genBusy = state != FGC_IDLE;

  // Payload sources
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      incByte <= 8'h00;
      lfsr <= 16'hace1;
    end else begin
      if (frameEnd || state == FGC_IDLE) begin
        incByte <= 8'h00;
      end else if (byteGo) begin
        incByte <= incByte + 8'h01;
      end
      if (byteGo) begin
        lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      end
    end
  end

  // Payload byte register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txByte <= '0;
    end else begin
      txByte.valid <= byteGo;
      txByte.last <= frameEnd;
      case (fgc_mode_e'(genCtrl[MODE_LSB+:2]))
        FGC_MODE_INC: txByte.data <= incByte;
        FGC_MODE_FIX: txByte.data <= genCtrl[FILL_LSB+:8];
        default: txByte.data <= lfsr[7:0];
      endcase
    end
  end

  // Read data
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (idx)
        IDX_GEN_CTRL: prdata <= {16'h0, genCtrl};
        IDX_PAT_LO: prdata <= {16'h0, patLo};
        IDX_PAT_MID: prdata <= {16'h0, patMid};
        IDX_PAT_HI: prdata <= {16'h0, patHi};
        IDX_DA_LO: prdata <= {16'h0, daLo};
        IDX_DA_MID: prdata <= {16'h0, daMid};
        IDX_DA_HI: prdata <= {16'h0, daHi};
        IDX_CHK_STATUS: prdata <= {21'h0, errOverflow, 10'h0};
        IDX_ERR_LO: prdata <= {16'h0, errShadow[15:0]};
        IDX_ERR_HI: prdata <= {16'h0, errShadow[31:16]};
        IDX_CRC_FLAGS: prdata <= {30'h0, crcFlags};
        IDX_TX_LO: prdata <= {16'h0, txCnt[15:0]};
        IDX_TX_HI: prdata <= {16'h0, txCnt[31:16]};
        IDX_TX_ERR: prdata <= {16'h0, txErrCnt};
        IDX_GEN_START: prdata <= {31'h0, genBusy};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // Checks
  AST_SAT: assert property (@(posedge clk) disable iff (!rst_b)
    errCnt == CNT_MAX && !countWrap && !clearWr |=> errCnt == CNT_MAX)
    else $error("errored count left saturation");
  AST_FREEZE: assert property (@(posedge clk) disable iff (!rst_b)
    freezeWr && !clearWr |=> errShadow == $past(errCnt))
    else $error("freeze did not capture count");
  AST_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    !freezeWr |=> errShadow == $past(errShadow))
    else $error("readable count moved without freeze");
  AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    clearWr |=> errCnt == {31'h0, $past(errEvt)} &&
      errOverflow == $past(errEvt && errCnt == CNT_MAX))
    else $error("clear failed");
  AST_RXCRC: assert property (@(posedge clk) disable iff (!rst_b)
    evt.rxFrameEnd |=> crcFlags[RX_CRC_BIT] == $past(evt.rxCrcBad))
    else $error("rx crc flag wrong");
  AST_TXCRC: assert property (@(posedge clk) disable iff (!rst_b)
    evt.txFrameEnd |=> crcFlags[TX_CRC_BIT] == $past(evt.txCrcBad))
    else $error("tx crc flag wrong");
  AST_TXCLR: assert property (@(posedge clk) disable iff (!rst_b)
    seqDone && !evt.txFrameEnd |=> txCnt == 32'h0 && txErrCnt == 16'h0)
    else $error("tx stats not cleared");
  AST_VLD: assert property (@(posedge clk) disable iff (!rst_b)
    patternBytes == ((genCtrl[VLD_LSB+:3] == 3'h7) ? MAX_VLD : genCtrl[VLD_LSB+:3]))
    else $error("pattern bytes above six");
  AST_INC: assert property (@(posedge clk) disable iff (!rst_b)
    byteGo && !frameEnd |=> incByte == $past(incByte) + 8'h01)
    else $error("incrementing byte wrong");
  AST_FIX: assert property (@(posedge clk) disable iff (!rst_b)
    genCtrl[MODE_LSB+:2] == 2'h1 |=> txByte.data == $past(genCtrl[FILL_LSB+:8]))
    else $error("fill byte not sent");
endmodule

// ### rtl/fgc_pkg.sv
// Package for the frame generator / checker register block.
// Assumes a 32-bit APB slave; register offsets are word indexes (byte address = 4 * index).
package fgc_pkg;
  localparam int unsigned ADDR_W = 16;
  // Register indexes
  localparam logic [11:0] IDX_GEN_CTRL = 12'h624;
  localparam logic [11:0] IDX_PAT_LO = 12'h625;
  localparam logic [11:0] IDX_PAT_MID = 12'h626;
  localparam logic [11:0] IDX_PAT_HI = 12'h627;
  localparam logic [11:0] IDX_DA_LO = 12'h628;
  localparam logic [11:0] IDX_DA_MID = 12'h629;
  localparam logic [11:0] IDX_DA_HI = 12'h62a;
  localparam logic [11:0] IDX_CHK_STATUS = 12'h620;
  localparam logic [11:0] IDX_ERR_LO = 12'h622;
  localparam logic [11:0] IDX_ERR_HI = 12'h623;
  localparam logic [11:0] IDX_CRC_FLAGS = 12'h638;
  localparam logic [11:0] IDX_TX_LO = 12'h639;
  localparam logic [11:0] IDX_TX_HI = 12'h63a;
  localparam logic [11:0] IDX_TX_ERR = 12'h63b;
  localparam logic [11:0] IDX_GEN_START = 12'h62b;
  // Reset values and field positions
  localparam logic [15:0] GEN_CTRL_RST = 16'h5511;
  localparam int unsigned FILL_LSB = 8;
  localparam int unsigned MODE_LSB = 6;
  localparam int unsigned VLD_LSB = 3;
  localparam int unsigned BURST_LSB = 0;
  localparam int unsigned FREEZE_BIT = 0;
  localparam int unsigned CLEAR_BIT = 1;
  localparam int unsigned RX_CRC_BIT = 1;
  localparam int unsigned TX_CRC_BIT = 0;
  localparam logic [2:0] MAX_VLD = 3'h6;
  localparam logic [2:0] BURST_CONT = 3'h7;
  localparam logic [31:0] CNT_MAX = 32'hffffffff;

  typedef enum logic [1:0] {
    FGC_MODE_INC = 2'h0,
    FGC_MODE_FIX = 2'h1,
    FGC_MODE_PRB = 2'h2,
    FGC_MODE_PRB2 = 2'h3
  } fgc_mode_e;

  // Generator state, Gray coded along idle -> send -> gap
  typedef enum logic [1:0] {
    FGC_IDLE = 2'b00,
    FGC_SEND = 2'b01,
    FGC_GAP = 2'b11
  } fgc_state_e;

  // Events reported by the frame checker and transmitter
  typedef struct packed {
    logic rxFrameEnd;
    logic rxCrcBad;
    logic rxDaMatch;
    logic txFrameEnd;
    logic txCrcBad;
  } fgc_evt_s;

  // Payload byte stream towards the transmit path
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } fgc_byte_s;
endpackage

// ### tb/testbench.sv
// Self-checking bench for the frame generator / checker register block.
// Assumes events are single-cycle pulses on the design's clock.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fgc_pkg::*;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  fgc_evt_s evt = '0;
  logic [47:0] rxDestAddr = '0;
  logic countWrap = 1'b0;
  logic txReady = 1'b0;
  fgc_byte_s txByte;
  logic [47:0] userPattern;
  logic [2:0] patternBytes;
  logic [47:0] destMatch;
  logic genBusy;
  int n_errors = 0;
  int n_checks = 0;
  int seed = 5;
  logic [32:0] expQ[$];
  logic [1:0] chkMode = 2'h0;
  logic [7:0] fill;
  logic [7:0] prevByte = '0;
  logic firstByte = 1'b1;
  logic [31:0] nFrames = '0;
  logic [15:0] pv[6];

  // Frames longer than 256 bytes so the incrementing payload wraps
  fgc_frame_gen_chk #(.FRAME_LEN(300)) uut (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr), .evt(evt), .rxDestAddr(rxDestAddr), .countWrap(countWrap),
    .txReady(txReady), .txByte(txByte), .userPattern(userPattern),
    .patternBytes(patternBytes), .destMatch(destMatch), .genBusy(genBusy));

  // Clock at 100 MHz
  always #5 clk = ~clk;

  // Compare one value and count it
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    if (expQ.size() != 0) n_errors++;
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One APB transfer; a read notes its expected answer {pslverr, prdata}
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                     input logic [32:0] exp);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    if (!wr) expQ.push_back(exp);
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] idx, input logic [15:0] v);
    apb(1'b0, idx, 32'h0, {17'h0, v});
  endtask

  task automatic wr(input logic [11:0] idx, input logic [15:0] v);
    apb(1'b1, idx, {16'h0, v}, 33'h0);
  endtask

  // One-cycle event pulse
  task automatic ev(input logic [4:0] e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
  endtask

  // Read answers are matched against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
      check({15'h0, pslverr, prdata}, {15'h0, expQ.pop_front()});
    end
  end

  // Payload monitor: fixed bytes equal the fill, incrementing bytes rise by one
  always @(posedge clk) begin
    if (txByte.valid === 1'b1) begin
      if (chkMode == 2'h1) check(txByte.data, fill);
      if (chkMode == 2'h2 && !firstByte) check(txByte.data, 8'(prevByte + 8'h1));
      prevByte <= txByte.data;
      firstByte <= txByte.last;
      if (txByte.last === 1'b1) nFrames <= nFrames + 1;
    end
  end

  // Downstream stalls at random
  always @(posedge clk) txReady <= rst_b & 1'($random(seed));

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    stop_test();
  end

  initial begin
    int n;
    logic [31:0] frameBase;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(IDX_GEN_CTRL, GEN_CTRL_RST);
    check(patternBytes, 3'h2);
    rd(IDX_PAT_HI, 16'h0);
    rd(IDX_DA_LO, 16'h0);
    rd(IDX_CRC_FLAGS, 16'h0);
    rd(IDX_TX_LO, 16'h0);
    rd(IDX_ERR_HI, 16'h0);
    apb(1'b0, 12'h7ff, 32'h0, {1'b1, 32'h0});
    for (int i = 0; i < 6; i++) begin
      pv[i] = 16'($random(seed));
      wr(12'(IDX_PAT_LO + i), pv[i]);
    end
    for (int i = 0; i < 6; i++) rd(12'(IDX_PAT_LO + i), pv[i]);
    check(userPattern, {pv[2], pv[1], pv[0]});
    check(destMatch, {pv[5], pv[4], pv[3]});
    wr(IDX_GEN_CTRL, 16'h5539);
    @(posedge clk);
    check(patternBytes, MAX_VLD);
    rxDestAddr <= {pv[5], pv[4], pv[3]};
    // Checksum flags follow the latest frame on each path
    ev(5'b11000);
    rd(IDX_CRC_FLAGS, 16'h2);
    ev(5'b00011);
    rd(IDX_CRC_FLAGS, 16'h3);
    ev(5'b10000);
    ev(5'b00010);
    ev(5'b00010);
    rd(IDX_CRC_FLAGS, 16'h0);
    // Sent-frame statistics clear after the ordered read
    rd(IDX_TX_LO, 16'h3);
    rd(IDX_TX_HI, 16'h0);
    rd(IDX_TX_ERR, 16'h1);
    rd(IDX_TX_LO, 16'h0);
    // Errored count: matching bad frames only, visible after a freeze
    ev(5'b11000);
    ev(5'b11000);
    rxDestAddr <= ~{pv[5], pv[4], pv[3]};
    ev(5'b11000);
    rxDestAddr <= {pv[5], pv[4], pv[3]};
    wr(IDX_CHK_STATUS, 16'h1);
    rd(IDX_ERR_LO, 16'h3);
    rd(IDX_ERR_HI, 16'h0);
    ev(5'b11000);
    rd(IDX_ERR_LO, 16'h3);
    wr(IDX_CHK_STATUS, 16'h2);
    wr(IDX_CHK_STATUS, 16'h1);
    rd(IDX_ERR_LO, 16'h0);
    // Each payload mode: incrementing runs ten frames, the rest one
    for (int m = 0; m < 4; m++) begin
      fill = 8'($random(seed));
      chkMode = (m == 0) ? 2'h2 : (m == 1) ? 2'h1 : 2'h0;
      wr(IDX_GEN_CTRL, {fill, m[1:0], 3'h0, (m == 0) ? 3'h1 : 3'h0});
      frameBase = nFrames;
      wr(IDX_GEN_START, 16'h1);
      // Busy rises at the same edge that takes the start write
      @(posedge clk);
      n = 0;
      while (genBusy !== 1'b0 && n < 20000) begin
        @(posedge clk);
        n++;
      end
      repeat (3) @(posedge clk);
      check(nFrames - frameBase, (m == 0) ? 32'd10 : 32'd1);
      check(genBusy, 1'b0);
    end
    // Continuous code keeps the generator running
    chkMode = 2'h0;
    wr(IDX_GEN_CTRL, {8'h55, 2'h1, 3'h0, BURST_CONT});
    wr(IDX_GEN_START, 16'h1);
    repeat (3000) @(posedge clk);
    check(genBusy, 1'b1);
    stop_test();
  end
endmodule
